// *** core/can_rx_pkg.sv ***
// Shared constants for the receive mailbox and filter configuration block
package can_rx_pkg;
   // Register byte offsets
   localparam logic [11:0] OFF_RX0_IDENT = 12'h1b0;
   localparam logic [11:0] OFF_RX0_LEN = 12'h1b4;
   localparam logic [11:0] OFF_RX0_DLOW = 12'h1b8;
   localparam logic [11:0] OFF_RX0_DHIGH = 12'h1bc;
   localparam logic [11:0] OFF_RX1_IDENT = 12'h1c0;
   localparam logic [11:0] OFF_RX1_LEN = 12'h1c4;
   localparam logic [11:0] OFF_RX1_DLOW = 12'h1c8;
   localparam logic [11:0] OFF_RX1_DHIGH = 12'h1cc;
   localparam logic [11:0] OFF_FILTER_CTRL = 12'h200;
   localparam logic [11:0] OFF_FILTER_MODE = 12'h204;
   localparam logic [11:0] OFF_FILTER_SCALE = 12'h20c;
   localparam logic [11:0] OFF_RX_RELEASE = 12'h240;
   localparam logic [11:0] OFF_RX_LEVEL = 12'h244;

   // Filter control fields and reset values
   localparam int CTRL_SETUP_BIT = 0;
   localparam int CTRL_BANK_LSB = 8;
   localparam int CTRL_BANK_W = 6;
   localparam logic [31:0] CTRL_RESERVED_READ = 32'h2a1c0000;
   localparam logic CTRL_SETUP_RESET = 1'b1;
   localparam logic [5:0] CTRL_BANK_RESET = 6'h0e;
   localparam logic [31:0] CTRL_RESET_WORD = 32'h2a1c0e01;
   localparam int NUM_BANKS = 28;
   localparam logic [27:0] BANK_BITS_RESET = 28'h0000000;

   // Mailbox word fields
   localparam int ID_REMOTE_BIT = 1;
   localparam int ID_KIND_BIT = 2;
   localparam int LEN_FILTER_LSB = 8;

   // Packed frame layout inside a receive FIFO entry
   localparam int F_IDENT_LSB = 0;
   localparam int F_KIND = 29;
   localparam int F_REMOTE = 30;
   localparam int F_LEN_LSB = 31;
   localparam int F_FILT_LSB = 35;
   localparam int F_DATA_LSB = 43;
   localparam int FRAME_W = 107;
   localparam int RX_DEPTH = 3;

   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage : can_rx_pkg

// *** core/can_rx_frame_fifo.sv ***
// Small frame FIFO with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module can_rx_frame_fifo #(
   parameter int WIDTH = 107,
   parameter int DEPTH = 3
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // Fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // Drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o,
   // Fill level
   output logic [$clog2(DEPTH+1)-1:0] level_o
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH+1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wr_ptr;
   logic [PW-1:0] rd_ptr;
   logic [CW-1:0] count;
   wire push;
   wire pop;

   // Pointer advance with explicit wrap, depth need not be a power of two
   function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
      bump = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
   endfunction : bump

   // Honest full and empty; a stalled drain really fills the store
   assign in_ready_o = (count != CW'(DEPTH));
   assign out_valid_o = (count != '0);
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;
   assign out_data_o = mem[rd_ptr];
   assign level_o = count;

   // Storage has no reset; contents of an empty slot are undefined
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end

   // Pointers and level
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) wr_ptr <= bump(wr_ptr);
         if (pop) rd_ptr <= bump(rd_ptr);
         count <= CW'(count + CW'(push) - CW'(pop));
      end
   end
endmodule : can_rx_frame_fifo
`default_nettype wire

// *** core/can_rx_mailbox_filter_config.sv ***
// Receive FIFO mailboxes and filter bank configuration behind AXI4-Lite
// What this block does
// - Mailbox registers ignore writes, show oldest frame
// - Identifier bit 1 flags remote frame
// - Bit 2 kind; 31:21 and 20:3 identifier
// - Length code in 3:0, zero for remote
// - Matched filter index in bits 15:8
// - Payload bytes 0-7 in low/high words
// - Control bit 0 selects filter setup mode
// - Control resets to 0x2a1c0e01
// - Bits 13:8 give second controller start bank
// - 28 all banks first, 0 all second
// - Control fields change only by software
// - Mode bits: mask mode or list mode
// - Scale bits: two 16-bit or one 32-bit
// - Mode and scale writable only in setup
// - Each FIFO holds three frames, shows oldest
`timescale 1ns/1ns
`default_nettype none
module can_rx_mailbox_filter_config #(
   parameter int DEPTH = can_rx_pkg::RX_DEPTH
) (
   // Clock and reset
   input wire logic CLK_I,
   input wire logic RESETN_I,
   // AXI4-Lite write address
   input wire logic [11:0] AWADDR_I,
   input wire logic AWVALID_I,
   output logic AWREADY_O,
   // AXI4-Lite write data
   input wire logic [31:0] WDATA_I,
   input wire logic [3:0] WSTRB_I,
   input wire logic WVALID_I,
   output logic WREADY_O,
   // AXI4-Lite write response
   output logic [1:0] BRESP_O,
   output logic BVALID_O,
   input wire logic BREADY_I,
   // AXI4-Lite read address
   input wire logic [11:0] ARADDR_I,
   input wire logic ARVALID_I,
   output logic ARREADY_O,
   // AXI4-Lite read data
   output logic [31:0] RDATA_O,
   output logic [1:0] RRESP_O,
   output logic RVALID_O,
   input wire logic RREADY_I,
   // Received frames from the acceptance datapath
   input wire logic FRAME_VALID_I,
   output logic FRAME_READY_O,
   input wire logic FRAME_FIFO_SEL_I,
   input wire logic [28:0] FRAME_IDENT_I,
   input wire logic FRAME_EXTENDED_I,
   input wire logic FRAME_REMOTE_I,
   input wire logic [3:0] FRAME_LENGTH_I,
   input wire logic [7:0] FRAME_FILTER_I,
   input wire logic [63:0] FRAME_DATA_I,
   // Filter configuration to the acceptance datapath
   output logic FILTER_SETUP_MODE_O,
   output logic [5:0] SECOND_START_BANK_O,
   output logic [27:0] FIRST_CONTROLLER_BANKS_O,
   output logic [27:0] FILTER_LIST_MODE_O,
   output logic [27:0] FILTER_WIDTH_O
);
   localparam int FW = can_rx_pkg::FRAME_W;
   localparam int CW = $clog2(DEPTH+1);

   // Write channel state
   logic aw_held;
   logic w_held;
   logic [11:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   logic bvalid;
   logic [1:0] bresp;
   // Read channel state
   logic rvalid;
   logic [31:0] rdata;
   logic [1:0] rresp;
   // Filter configuration
   logic filter_setup_mode;
   logic [5:0] second_controller_start_bank;
   logic [27:0] filter_list_mode_bits;
   logic [27:0] filter_width_bits;
   // Receive FIFO wiring
   logic [1:0] rx_in_ready;
   logic [1:0] rx_out_valid;
   logic [FW-1:0] head0;
   logic [FW-1:0] head1;
   logic [CW-1:0] level0;
   logic [CW-1:0] level1;
   logic [1:0] release_pulse;

   // Mailbox identifier word from a stored frame
   function automatic logic [31:0] ident_word(input logic [FW-1:0] f);
      logic [28:0] id;
      id = f[can_rx_pkg::F_IDENT_LSB +: 29];
      ident_word = '0;
      ident_word[can_rx_pkg::ID_REMOTE_BIT] = f[can_rx_pkg::F_REMOTE];
      ident_word[can_rx_pkg::ID_KIND_BIT] = f[can_rx_pkg::F_KIND];
      // Short identifier sits in the top field, low field reads zero
      if (f[can_rx_pkg::F_KIND]) begin
         ident_word[31:3] = id;
      end else begin
         ident_word[31:21] = id[10:0];
      end
   endfunction : ident_word

   // Mailbox length word: code, matched filter, reserved zero
   function automatic logic [31:0] length_word(input logic [FW-1:0] f);
      length_word = '0;
      if (!f[can_rx_pkg::F_REMOTE]) begin
         length_word[3:0] = f[can_rx_pkg::F_LEN_LSB +: 4];
      end
      length_word[can_rx_pkg::LEN_FILTER_LSB +: 8] = f[can_rx_pkg::F_FILT_LSB +: 8];
   endfunction : length_word

   // Byte-lane merge of a write onto an old value
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      for (int i = 0; i < 4; i++) begin
         merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
      end
   endfunction : merge

   // Frame routing: the ready seen by the source is the chosen FIFO's room
   wire [FW-1:0] frame_in = {FRAME_DATA_I, FRAME_FILTER_I, FRAME_LENGTH_I,
                             FRAME_REMOTE_I, FRAME_EXTENDED_I, FRAME_IDENT_I};
   wire in_valid0 = FRAME_VALID_I && !FRAME_FIFO_SEL_I;
   wire in_valid1 = FRAME_VALID_I && FRAME_FIFO_SEL_I;
   assign FRAME_READY_O = FRAME_FIFO_SEL_I ? rx_in_ready[1] : rx_in_ready[0];

   // Three-frame store per receive FIFO, head shown by the mailbox
   can_rx_frame_fifo #(.WIDTH(FW), .DEPTH(DEPTH)) u_fifo0 (
      .clk_i(CLK_I),
      .resetn_i(RESETN_I),
      .in_valid_i(in_valid0),
      .in_ready_o(rx_in_ready[0]),
      .in_data_i(frame_in),
      .out_valid_o(rx_out_valid[0]),
      .out_ready_i(release_pulse[0]),
      .out_data_o(head0),
      .level_o(level0)
   );
   can_rx_frame_fifo #(.WIDTH(FW), .DEPTH(DEPTH)) u_fifo1 (
      .clk_i(CLK_I),
      .resetn_i(RESETN_I),
      .in_valid_i(in_valid1),
      .in_ready_o(rx_in_ready[1]),
      .in_data_i(frame_in),
      .out_valid_o(rx_out_valid[1]),
      .out_ready_i(release_pulse[1]),
      .out_data_o(head1),
      .level_o(level1)
   );

   // Write decode; a write commits once both address and data are held
   wire wr_commit = aw_held && w_held && !bvalid;
   wire wr_ctrl = wr_commit && (wr_addr == can_rx_pkg::OFF_FILTER_CTRL);
   wire wr_mode = wr_commit && (wr_addr == can_rx_pkg::OFF_FILTER_MODE);
   wire wr_scale = wr_commit && (wr_addr == can_rx_pkg::OFF_FILTER_SCALE);
   wire wr_release = wr_commit && (wr_addr == can_rx_pkg::OFF_RX_RELEASE);
   wire wr_mailbox = wr_commit && (wr_addr[11:4] == can_rx_pkg::OFF_RX0_IDENT[11:4] ||
                                   wr_addr[11:4] == can_rx_pkg::OFF_RX1_IDENT[11:4]);
   wire wr_mapped = wr_ctrl || wr_mode || wr_scale || wr_release || wr_mailbox ||
                    (wr_addr == can_rx_pkg::OFF_RX_LEVEL);
   // Release only pops a FIFO that holds a frame; empty release is harmless
   assign release_pulse[0] = wr_release && wr_strb[0] && wr_data[0];
   assign release_pulse[1] = wr_release && wr_strb[0] && wr_data[1];

   // Current register words
   wire [31:0] ctrl_word = can_rx_pkg::CTRL_RESERVED_READ |
                           {18'h0, second_controller_start_bank, 7'h0, filter_setup_mode};
   wire [31:0] mode_word = {4'h0, filter_list_mode_bits};
   wire [31:0] scale_word = {4'h0, filter_width_bits};
   wire [31:0] ctrl_next = merge(ctrl_word, wr_data, wr_strb);
   wire [31:0] mode_next = merge(mode_word, wr_data, wr_strb);
   wire [31:0] scale_next = merge(scale_word, wr_data, wr_strb);

   // Write address and data channels, taken in either order
   assign AWREADY_O = !aw_held && !bvalid;
   assign WREADY_O = !w_held && !bvalid;
   always_ff @(posedge CLK_I) begin
      if (!RESETN_I) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         wr_addr <= 12'h000;
         wr_data <= 32'h00000000;
         wr_strb <= 4'h0;
      end else begin
         if (AWVALID_I && AWREADY_O) begin
            aw_held <= 1'b1;
            wr_addr <= {AWADDR_I[11:2], 2'h0};
         end else if (wr_commit) begin
            aw_held <= 1'b0;
         end
         if (WVALID_I && WREADY_O) begin
            w_held <= 1'b1;
            wr_data <= WDATA_I;
            wr_strb <= WSTRB_I;
         end else if (wr_commit) begin
            w_held <= 1'b0;
         end
      end
   end

   // Write response, one cycle after the commit
   assign BVALID_O = bvalid;
   assign BRESP_O = bresp;
   always_ff @(posedge CLK_I) begin
      if (!RESETN_I) begin
         bvalid <= 1'b0;
         bresp <= can_rx_pkg::RESP_OKAY;
      end else if (wr_commit) begin
         bvalid <= 1'b1;
         bresp <= wr_mapped ? can_rx_pkg::RESP_OKAY : can_rx_pkg::RESP_DECERR;
      end else if (BREADY_I) begin
         bvalid <= 1'b0;
      end
   end

   // Filter control: only software moves these fields
   always_ff @(posedge CLK_I) begin
      if (!RESETN_I) begin
         filter_setup_mode <= can_rx_pkg::CTRL_SETUP_RESET;
         second_controller_start_bank <= can_rx_pkg::CTRL_BANK_RESET;
      end else if (wr_ctrl) begin
         filter_setup_mode <= ctrl_next[can_rx_pkg::CTRL_SETUP_BIT];
         second_controller_start_bank <=
            ctrl_next[can_rx_pkg::CTRL_BANK_LSB +: can_rx_pkg::CTRL_BANK_W];
      end
   end

   // Bank mode and scale; locked outside setup mode so live filters stay coherent
   always_ff @(posedge CLK_I) begin
      if (!RESETN_I) begin
         filter_list_mode_bits <= can_rx_pkg::BANK_BITS_RESET;
         filter_width_bits <= can_rx_pkg::BANK_BITS_RESET;
      end else begin
         if (wr_mode && filter_setup_mode) begin
            filter_list_mode_bits <= mode_next[27:0];
         end
         if (wr_scale && filter_setup_mode) begin
            filter_width_bits <= scale_next[27:0];
         end
      end
   end

   // Read decode; mailbox words come straight from the FIFO heads
   wire [11:0] rd_addr = {ARADDR_I[11:2], 2'h0};
   wire [31:0] level_word = {24'h0, 2'h0, 2'(level1), 2'h0, 2'(level0)};
   logic [31:0] next_rdata;
   logic next_rmapped;
   always_comb begin
      next_rmapped = 1'b1;
      case (rd_addr)
         can_rx_pkg::OFF_RX0_IDENT: next_rdata = ident_word(head0);
         can_rx_pkg::OFF_RX0_LEN: next_rdata = length_word(head0);
         can_rx_pkg::OFF_RX0_DLOW: next_rdata = head0[can_rx_pkg::F_DATA_LSB +: 32];
         can_rx_pkg::OFF_RX0_DHIGH: next_rdata = head0[can_rx_pkg::F_DATA_LSB+32 +: 32];
         can_rx_pkg::OFF_RX1_IDENT: next_rdata = ident_word(head1);
         can_rx_pkg::OFF_RX1_LEN: next_rdata = length_word(head1);
         can_rx_pkg::OFF_RX1_DLOW: next_rdata = head1[can_rx_pkg::F_DATA_LSB +: 32];
         can_rx_pkg::OFF_RX1_DHIGH: next_rdata = head1[can_rx_pkg::F_DATA_LSB+32 +: 32];
         can_rx_pkg::OFF_FILTER_CTRL: next_rdata = ctrl_word;
         can_rx_pkg::OFF_FILTER_MODE: next_rdata = mode_word;
         can_rx_pkg::OFF_FILTER_SCALE: next_rdata = scale_word;
         can_rx_pkg::OFF_RX_RELEASE: next_rdata = 32'h00000000;
         can_rx_pkg::OFF_RX_LEVEL: next_rdata = level_word;
         default: begin
            next_rdata = 32'h00000000;
            next_rmapped = 1'b0;
         end
      endcase
   end

   // Read channel: one read in flight, data registered
   assign ARREADY_O = !rvalid;
   assign RVALID_O = rvalid;
   assign RDATA_O = rdata;
   assign RRESP_O = rresp;
   always_ff @(posedge CLK_I) begin
      if (!RESETN_I) begin
         rvalid <= 1'b0;
         rdata <= 32'h00000000;
         rresp <= can_rx_pkg::RESP_OKAY;
      end else if (ARVALID_I && ARREADY_O) begin
         rvalid <= 1'b1;
         rdata <= next_rdata;
         rresp <= next_rmapped ? can_rx_pkg::RESP_OKAY : can_rx_pkg::RESP_DECERR;
      end else if (RREADY_I) begin
         rvalid <= 1'b0;
      end
   end

   // Bank ownership: banks below the start bank serve the first controller
   genvar b;
   generate
      for (b = 0; b < can_rx_pkg::NUM_BANKS; b++) begin : g_bank
         assign FIRST_CONTROLLER_BANKS_O[b] = (6'(b) < second_controller_start_bank);
      end
   endgenerate

   // Configuration outputs
   assign FILTER_SETUP_MODE_O = filter_setup_mode;
   assign SECOND_START_BANK_O = second_controller_start_bank;
   assign FILTER_LIST_MODE_O = filter_list_mode_bits;
   assign FILTER_WIDTH_O = filter_width_bits;

   // Checks on the register view and the configuration
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RESETN_I);

   a_mailbox_ignores_write: assert property (
      wr_mailbox |=> $stable(ctrl_word) && $stable(mode_word) && $stable(scale_word))
      else $error("Mailbox write disturbed configuration");
   a_remote_flag_read: assert property (
      (ARVALID_I && ARREADY_O && rd_addr == can_rx_pkg::OFF_RX0_IDENT && rx_out_valid[0])
      |=> RDATA_O[1] == $past(head0[can_rx_pkg::F_REMOTE]) && !RDATA_O[0])
      else $error("Remote flag misread");
   a_short_ident_zero: assert property (
      (ARVALID_I && ARREADY_O && rd_addr == can_rx_pkg::OFF_RX1_IDENT && rx_out_valid[1]
       && !head1[can_rx_pkg::F_KIND]) |=> RDATA_O[20:3] == 18'h0 && !RDATA_O[2])
      else $error("Short identifier word wrong");
   a_remote_length_zero: assert property (
      (ARVALID_I && ARREADY_O && rd_addr == can_rx_pkg::OFF_RX0_LEN && rx_out_valid[0]
       && head0[can_rx_pkg::F_REMOTE]) |=> RDATA_O[3:0] == 4'h0 && RDATA_O[7:4] == 4'h0)
      else $error("Remote frame length not zero");
   a_control_reset_word: assert property (
      $rose(RESETN_I) |-> ctrl_word == can_rx_pkg::CTRL_RESET_WORD)
      else $error("Control reset value wrong");
   a_bank_split_ends: assert property (
      (second_controller_start_bank == 6'd28 |-> FIRST_CONTROLLER_BANKS_O == 28'hfffffff) and
      (second_controller_start_bank == 6'd0 |-> FIRST_CONTROLLER_BANKS_O == 28'h0000000))
      else $error("Bank split wrong");
   a_control_sw_only: assert property (
      !wr_ctrl |=> $stable(filter_setup_mode) && $stable(second_controller_start_bank))
      else $error("Control changed without write");
   a_mode_locked: assert property (
      ((wr_mode || wr_scale) && !filter_setup_mode)
      |=> $stable(filter_list_mode_bits) && $stable(filter_width_bits))
      else $error("Bank config changed outside setup");
   a_scale_write_lands: assert property (
      (wr_scale && filter_setup_mode && wr_strb == 4'hf)
      |=> filter_width_bits == $past(wr_data[27:0]))
      else $error("Scale write lost");
   a_head_holds: assert property (
      (rx_out_valid[0] && !release_pulse[0]) |=> $stable(head0) && rx_out_valid[0])
      else $error("Mailbox head moved without release");
   a_release_advances: assert property (
      (release_pulse[0] && rx_out_valid[0] && !in_valid0)
      |=> level0 == CW'($past(level0) - 1'b1))
      else $error("Release did not advance FIFO");
   a_read_answer: assert property (
      (ARVALID_I && ARREADY_O) |=> RVALID_O [*1] ##0 !ARREADY_O)
      else $error("Read not answered next cycle");

   c_fifo_full: cover property (level0 == CW'(DEPTH) && FRAME_VALID_I && !FRAME_FIFO_SEL_I);
   c_release_then_read: cover property (release_pulse[1] ##[1:8] (ARVALID_I && ARREADY_O));
   c_locked_write: cover property (wr_mode && !filter_setup_mode);
   c_split_all_second: cover property (second_controller_start_bank == 6'd0);
endmodule : can_rx_mailbox_filter_config
`default_nettype wire

// *** test/can_frame_source.sv ***
// Frame source model standing in for the acceptance datapath
`timescale 1ns/1ns
`default_nettype none
module can_frame_source (
   // Clock and handshake
   input wire logic clk_i,
   input wire logic ready_i,
   output logic valid_o,
   // Frame fields
   output logic sel_o,
   output logic [28:0] ident_o,
   output logic ext_o,
   output logic rem_o,
   output logic [3:0] len_o,
   output logic [7:0] filt_o,
   output logic [63:0] data_o
);
   initial {valid_o, sel_o, ident_o, ext_o, rem_o, len_o, filt_o, data_o} = '0;
   // Offer one frame a cycle late, hold it until taken, then scramble released fields
   task automatic send(input logic s, input logic [28:0] id, input logic e, input logic r,
      input logic [3:0] l, input logic [7:0] f, input logic [63:0] d);
      @(posedge clk_i);
      valid_o <= 1'b1;
      {sel_o, ident_o, ext_o, rem_o, len_o, filt_o, data_o} <= {s, id, e, r, l, f, d};
      do @(posedge clk_i); while (!ready_i);
      valid_o <= 1'b0;
      {sel_o, ident_o, ext_o, rem_o, len_o, filt_o, data_o} <= ~{s, id, e, r, l, f, d};
   endtask : send
endmodule : can_frame_source
`default_nettype wire

// *** test/tb_top.sv ***
// Self-checking bench for the receive mailbox and filter configuration block
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin err_total++; \
   $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module tb_top;
   logic clk = 1'b0, rstn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic [11:0] awaddr = 12'h0, araddr = 12'h0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hf;
   wire logic awready, wready, bvalid, arready, rvalid, fvalid, fready, fsel, fext, frem, setup;
   wire logic [1:0] bresp, rresp;
   wire logic [31:0] rdata;
   wire logic [28:0] fid;
   wire logic [3:0] flen;
   wire logic [7:0] fflt;
   wire logic [63:0] fdat;
   wire logic [5:0] sbank;
   wire logic [27:0] fbanks, lmode, wmode;
   int err_total = 0, checks = 0;
   // Frame table: identifier, kind, remote, length, filter, payload
   logic [28:0] tid [4] = '{29'h1abcdef3, 29'h000005a5, 29'h000007ff, 29'h00000123};
   logic [3:0] text = 4'b1001, trem = 4'b0010;
   logic [3:0] tlen [4] = '{4'h8, 4'h5, 4'h0, 4'h3};
   logic [7:0] tflt [4] = '{8'h03, 8'h1b, 8'hff, 8'h00};
   logic [63:0] tdat [4] = '{64'h8877665544332211, 64'h0123456789abcdef,
      64'hfedcba9876543210, 64'h00000000deadbeef};

   always #20 clk = ~clk;

   can_rx_mailbox_filter_config #(.DEPTH(3)) can_rx_mailbox_filter_config_inst (
      .CLK_I(clk), .RESETN_I(rstn), .AWADDR_I(awaddr), .AWVALID_I(awvalid),
      .AWREADY_O(awready), .WDATA_I(wdata), .WSTRB_I(wstrb), .WVALID_I(wvalid),
      .WREADY_O(wready), .BRESP_O(bresp), .BVALID_O(bvalid), .BREADY_I(bready),
      .ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(arready), .RDATA_O(rdata),
      .RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready), .FRAME_VALID_I(fvalid),
      .FRAME_READY_O(fready), .FRAME_FIFO_SEL_I(fsel), .FRAME_IDENT_I(fid),
      .FRAME_EXTENDED_I(fext), .FRAME_REMOTE_I(frem), .FRAME_LENGTH_I(flen),
      .FRAME_FILTER_I(fflt), .FRAME_DATA_I(fdat), .FILTER_SETUP_MODE_O(setup),
      .SECOND_START_BANK_O(sbank), .FIRST_CONTROLLER_BANKS_O(fbanks),
      .FILTER_LIST_MODE_O(lmode), .FILTER_WIDTH_O(wmode));

   can_frame_source can_frame_source_inst (.clk_i(clk), .ready_i(fready), .valid_o(fvalid),
      .sel_o(fsel), .ident_o(fid), .ext_o(fext), .rem_o(frem), .len_o(flen),
      .filt_o(fflt), .data_o(fdat));

   // Bus write: address and data offered together, each dropped once taken
   task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw = 1'b1;
      logic w = 1'b1;
      {awaddr, wdata, awvalid, wvalid} <= {a, d, 2'b11};
      while (aw || w) begin
         @(posedge clk);
         aw = aw && !awready;
         w = w && !wready;
         awvalid <= aw;
         wvalid <= w;
      end
      bready <= 1'b1;
      do @(posedge clk); while (!bvalid);
      r = bresp;
      bready <= 1'b0;
   endtask : wr

   // Bus read: response ready raised only after the address is taken
   task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      {araddr, arvalid} <= {a, 1'b1};
      do @(posedge clk); while (!arready);
      arvalid <= 1'b0;
      rready <= 1'b1;
      do @(posedge clk); while (!rvalid);
      {d, r} = {rdata, rresp};
      rready <= 1'b0;
   endtask : rd

   task automatic rc(input logic [11:0] a, input logic [31:0] ex, input string nm);
      logic [31:0] d;
      logic [1:0] r;
      rd(a, d, r);
      `CHK(nm, ex, d)
      `CHK("rresp", can_rx_pkg::RESP_OKAY, r)
   endtask : rc

   task automatic wc(input logic [11:0] a, input logic [31:0] d);
      logic [1:0] r;
      wr(a, d, r);
      `CHK("bresp", can_rx_pkg::RESP_OKAY, r)
   endtask : wc

   task automatic snd(input logic s, input int k);
      can_frame_source_inst.send(s, tid[k], text[k], trem[k], tlen[k], tflt[k], tdat[k]);
   endtask : snd

   // Mailbox words expected for table entry k; remote payload is left unchecked
   task automatic mbox(input logic [11:0] b, input int k);
      rc(b, text[k] ? {tid[k], 1'b1, trem[k], 1'b0}
         : {tid[k][10:0], 18'h0, 1'b0, trem[k], 1'b0}, "ident");
      rc(b + 12'h4, {16'h0, tflt[k], 4'h0, trem[k] ? 4'h0 : tlen[k]}, "length");
      if (!trem[k]) begin
         rc(b + 12'h8, tdat[k][31:0], "data low");
         rc(b + 12'hc, tdat[k][63:32], "data high");
      end
   endtask : mbox

   task automatic t_reset;
      rc(can_rx_pkg::OFF_FILTER_CTRL, 32'h2a1c0e01, "ctrl");
      rc(can_rx_pkg::OFF_FILTER_MODE, 32'h0, "mode");
      rc(can_rx_pkg::OFF_FILTER_SCALE, 32'h0, "scale");
      `CHK("setup", 1'b1, setup)
      `CHK("banks", 28'h0003fff, fbanks)
   endtask : t_reset

   // Mode and scale writes stick only in setup mode; start bank edges
   task automatic t_filter;
      wc(can_rx_pkg::OFF_FILTER_MODE, 32'hfaaaaaa5);
      rc(can_rx_pkg::OFF_FILTER_MODE, 32'h0aaaaaa5, "mode");
      `CHK("list", 28'haaaaaa5, lmode)
      wc(can_rx_pkg::OFF_FILTER_SCALE, 32'h05555558);
      `CHK("width", 28'h5555558, wmode)
      wc(can_rx_pkg::OFF_FILTER_CTRL, 32'hffffdc00);
      rc(can_rx_pkg::OFF_FILTER_CTRL, 32'h2a1c1c00, "ctrl");
      `CHK("banks", 28'hfffffff, fbanks)
      wc(can_rx_pkg::OFF_FILTER_MODE, 32'h0);
      wc(can_rx_pkg::OFF_FILTER_SCALE, 32'h0);
      rc(can_rx_pkg::OFF_FILTER_MODE, 32'h0aaaaaa5, "mode");
      `CHK("width", 28'h5555558, wmode)
      wc(can_rx_pkg::OFF_FILTER_CTRL, 32'h0);
      `CHK("banks", 28'h0, fbanks)
      wc(can_rx_pkg::OFF_FILTER_CTRL, 32'h00000501);
      `CHK("setup", 1'b1, setup)
      `CHK("start", 6'h05, sbank)
      `CHK("banks", 28'h000001f, fbanks)
   endtask : t_filter

   // Fill FIFO0 until it refuses, poke read-only words, release in order
   task automatic t_fifo;
      snd(1'b0, 0);
      snd(1'b0, 1);
      snd(1'b0, 2);
      fork
         snd(1'b0, 3);
         begin
            repeat (4) @(posedge clk);
            `CHK("ready", 1'b0, fready)
            rc(can_rx_pkg::OFF_RX_LEVEL, 32'h3, "level");
            wc(can_rx_pkg::OFF_RX0_IDENT, 32'h0);
            wc(can_rx_pkg::OFF_RX0_DLOW, 32'h0);
            mbox(can_rx_pkg::OFF_RX0_IDENT, 0);
            wc(can_rx_pkg::OFF_RX_RELEASE, 32'h1);
         end
      join
      mbox(can_rx_pkg::OFF_RX0_IDENT, 1);
      wc(can_rx_pkg::OFF_RX_RELEASE, 32'h1);
      mbox(can_rx_pkg::OFF_RX0_IDENT, 2);
      wc(can_rx_pkg::OFF_RX_RELEASE, 32'h1);
      mbox(can_rx_pkg::OFF_RX0_IDENT, 3);
      snd(1'b1, 0);
      snd(1'b1, 2);
      rc(can_rx_pkg::OFF_RX_LEVEL, 32'h21, "level");
      mbox(can_rx_pkg::OFF_RX1_IDENT, 0);
      wc(can_rx_pkg::OFF_RX_RELEASE, 32'h2);
      mbox(can_rx_pkg::OFF_RX1_IDENT, 2);
      rc(can_rx_pkg::OFF_RX_LEVEL, 32'h11, "level");
      rc(can_rx_pkg::OFF_FILTER_CTRL, 32'h2a1c0501, "ctrl");
   endtask : t_fifo

   // Unmapped addresses answer with a decode error
   task automatic t_bus;
      logic [31:0] d;
      logic [1:0] r;
      rd(12'h100, d, r);
      `CHK("rresp", can_rx_pkg::RESP_DECERR, r)
      `CHK("rdata", 32'h0, d)
      wr(12'h300, 32'h1, r);
      `CHK("bresp", can_rx_pkg::RESP_DECERR, r)
   endtask : t_bus

   task automatic end_sim;
      if (err_total == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : end_sim

   initial begin
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      t_reset();
      t_filter();
      t_fifo();
      t_bus();
      end_sim();
   end

   // Watchdog well beyond the hundred or so cycles the tests need
   initial begin
      repeat (5000) @(posedge clk);
      err_total++;
      end_sim();
   end
endmodule : tb_top
`default_nettype wire
